// ---- rtl/serial_ctrl_pkg.sv ----
// constants, register map and field layout of the channel read-status block
package serial_ctrl_pkg;

    // ------------------------------------------------------------
    // register byte addresses, one aligned word each
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BUF_EXT_STATUS = 8'h00;
    localparam logic [7:0] OFS_SPECIAL_RX = 8'h04;
    localparam logic [7:0] OFS_VECTOR_CHAN_A = 8'h08;
    localparam logic [7:0] OFS_PENDING_CHAN_A = 8'h0c;
    localparam logic [7:0] OFS_FRAME_COUNT_LOW = 8'h10;
    localparam logic [7:0] OFS_FRAME_COUNT_HIGH = 8'h14;
    localparam logic [7:0] OFS_RECEIVE_DATA = 8'h18;
    localparam logic [7:0] OFS_VECTOR_CHAN_B = 8'h1c;
    localparam logic [7:0] OFS_PENDING_CHAN_B = 8'h20;
    localparam logic [7:0] OFS_CONFIG = 8'h24;
    localparam logic [7:0] OFS_VECTOR_WRITE = 8'h28;
    localparam logic [7:0] OFS_COMMAND = 8'h2c;

    // ------------------------------------------------------------
    // config register fields
    // ------------------------------------------------------------
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_ZC_IE = 2;
    localparam int CFG_FRAME_FIFO_EN = 3;
    localparam int CFG_STATUS_HIGH = 4;
    localparam int CFG_PARITY_EN = 5;
    localparam int CFG_PARITY_SPECIAL = 6;
    localparam int CFG_CRC_EN = 7;
    localparam int CFG_CHAR_LEN_LSB = 8;
    localparam logic [9:0] CFG_RESET = 10'h000;
    localparam logic [7:0] VECTOR_RESET = 8'h00;

    // command register bits, write-one pulses
    localparam int CMD_ERROR_RESET = 0;
    localparam int CMD_ES_RESET = 1;
    localparam int CMD_CHANNEL_RESET = 2;

    // operating modes
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SDLC = 2'h2;

    // character lengths
    localparam logic [1:0] LEN_5 = 2'h0;
    localparam logic [1:0] LEN_6 = 2'h1;
    localparam logic [1:0] LEN_7 = 2'h2;
    localparam logic [1:0] LEN_8 = 2'h3;

    // residue codes, bits 2..1..0
    localparam logic [2:0] RES_RESET = 3'h3;
    localparam logic [2:0] RES_NONE_8 = 3'h6;
    localparam logic [2:0] RES_NONE_7 = 3'h0;
    localparam logic [2:0] RES_NONE_6 = 3'h2;
    localparam logic [2:0] RES_NONE_5 = 3'h4;

    // vector status when nothing is pending
    localparam logic [2:0] VEC_NONE_LOW = 3'h3;
    localparam logic [2:0] VEC_NONE_HIGH = 3'h6;

    // ------------------------------------------------------------
    // fifo geometry and entry layout
    // ------------------------------------------------------------
    localparam int RX_W = 16;
    localparam int RX_DEPTH = 3;
    localparam int RX_PAR = 8;
    localparam int RX_FRM = 9;
    localparam int RX_CRC = 10;
    localparam int RX_EOF = 11;
    localparam int RX_RES_LSB = 12;
    localparam int RX_OVR = 15;
    localparam int FR_W = 19;
    localparam int FR_DEPTH = 10;
    localparam int FR_COUNT_W = 14;
    localparam int FR_CRC = 18;
    localparam int FR_RES_LSB = 15;

    // ext/status interrupt service states
    typedef enum logic [2:0] {
        ES_IDLE = 3'b001,
        ES_PENDING = 3'b010,
        ES_ZC_QUEUED = 3'b100
    } es_state_t;

endpackage

// ---- rtl/status_fifo.sv ----
// flip-flop fifo, oldest entry at index zero, optional overwrite of the newest when full
`timescale 1ns/10ps
module status_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 3,
    parameter bit OVERWRITE = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    input wire logic pop,
    output logic [WIDTH-1:0] topData,
    output logic notEmpty,
    output logic full
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-1:0] used;
    logic doPop;
    logic doPush;
    logic grow;
    logic [CW-1:0] wrIdx;

    // a full fifo without overwrite drops the push; the caller sees full
    assign doPop = pop && (used != '0);
    assign doPush = push && (used != DEPTH_C || doPop || OVERWRITE);
    assign grow = push && (used != DEPTH_C || doPop);
    assign wrIdx = doPop ? used - CW'(1) : ((used == DEPTH_C) ? DEPTH_C - CW'(1) : used);
    assign topData = mem[0];
    assign notEmpty = (used != '0);
    assign full = (used == DEPTH_C);

    // fill level
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            used <= '0;
        end else if (grow && !doPop) begin
            used <= used + CW'(1);
        end else if (doPop && !grow) begin
            used <= used - CW'(1);
        end
    end

    // storage: push slot wins, others shift toward the head on pop
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (rst || flush) begin
                mem[i] <= '0;
            end else if (doPush && wrIdx == CW'(i)) begin
                mem[i] <= pushData;
            end else if (doPop) begin
                mem[i] <= (i < DEPTH - 1) ? mem[(i < DEPTH - 1) ? i + 1 : i] : mem[i];
            end
        end
    end
endmodule

// ---- rtl/serial_ctrl_read_status_regs.sv ----
// read-side status registers of one serial channel, reached over apb
//
// How it works
// - zero-count bit follows counter at zero
// - zero-count interrupt waits while another pending
// - zero-count unlatched, rise closes status latches
// - rx available tracks fifo; reset empties
// - end of frame only in sdlc
// - async framing error unlatched, half-bit stretch
// - crc bit per character, cleared by reset
// - frame fifo supplies crc status
// - overrun flags overwriting char, then latches
// - parity error latched until error reset
// - residue resets to 011, forced async
// - eight-bit residue codes passed through
// - boundary residue code per character length
// - all sent async real, else one
// - channel b vector carries inserted status
// - no pending inserts 011 or 110
// - one vector register for both channels
// - pending register only in channel a
// - byte count low from frame fifo
// - byte count high, bit7 overflow
// - bit6 shows frame fifo not empty
// - zero-count enable, cleared by reset
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module serial_ctrl_read_status_regs
    import serial_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic brgZero,
    input wire logic rxPush,
    input wire logic [7:0] rxData,
    input wire logic rxParityErr,
    input wire logic rxFrameErr,
    input wire logic rxCrcErr,
    input wire logic rxEndOfFrame,
    input wire logic rxOnBoundary,
    input wire logic [2:0] rxResidue,
    input wire logic txAllSent,
    input wire logic frameDone,
    input wire logic [13:0] frameByteCount,
    input wire logic frameCrcErr,
    input wire logic [2:0] frameResidue,
    input wire logic [5:0] ipPending,
    input wire logic [2:0] vectorStatus,
    output logic extStatusIrq,
    output logic extLatchClose,
    output logic extendHalfBit,
    output logic specialRxCond
);
    // ------------------------------------------------------------
    // bus decode and software state
    // ------------------------------------------------------------
    logic access;
    logic done;
    logic wrDone;
    logic rdDone;
    logic [9:0] cfg;
    logic [7:0] vectorReg;
    logic errReset;
    logic esReset;
    logic chanReset;
    logic [1:0] mode;
    logic isAsync;
    logic isSdlc;
    logic frameFifoOn;

    assign access = psel && penable;
    assign done = access && pready;
    assign wrDone = done && pwrite;
    assign rdDone = done && !pwrite;
    assign errReset = wrDone && paddr == OFS_COMMAND && pwdata[CMD_ERROR_RESET];
    assign esReset = wrDone && paddr == OFS_COMMAND && pwdata[CMD_ES_RESET];
    assign chanReset = wrDone && paddr == OFS_COMMAND && pwdata[CMD_CHANNEL_RESET];
    assign mode = cfg[CFG_MODE_LSB +: 2];
    assign isAsync = (mode == MODE_ASYNC);
    assign isSdlc = (mode == MODE_SDLC);
    assign frameFifoOn = isSdlc && cfg[CFG_FRAME_FIFO_EN];

    // config register; channel reset drops the zero-count enable
    // enable cleared on reset
    always_ff @(posedge clk) begin
        if (rst || chanReset) begin
            cfg <= CFG_RESET;
        end else if (wrDone && paddr == OFS_CONFIG) begin
            cfg <= pwdata[9:0];
        end
    end

    // single vector register shared by both channel views
    // one stored vector
    always_ff @(posedge clk) begin
        if (rst) begin
            vectorReg <= VECTOR_RESET;
        end else if (wrDone && paddr == OFS_VECTOR_WRITE) begin
            vectorReg <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // zero count and ext/status service
    // ------------------------------------------------------------
    logic zcLive;
    logic zcRise;
    es_state_t esState;
    es_state_t next_esState;

    // level only, never latched high
    // live zero-count level
    always_ff @(posedge clk) begin
        if (rst) begin
            zcLive <= 1'b0;
        end else begin
            zcLive <= cfg[CFG_ZC_IE] && brgZero;
        end
    end
    assign zcRise = cfg[CFG_ZC_IE] && brgZero && !zcLive;

    // a queued zero count is re-checked when service ends, and dropped if gone
    // defer while pending
    always_comb begin
        next_esState = esState;
        case (esState)
            ES_IDLE: begin
                if (zcRise) begin
                    next_esState = ES_PENDING;
                end
            end
            ES_PENDING: begin
                if (zcRise) begin
                    next_esState = ES_ZC_QUEUED;
                end else if (esReset) begin
                    next_esState = ES_IDLE;
                end
            end
            ES_ZC_QUEUED: begin
                if (esReset) begin
                    next_esState = zcLive ? ES_PENDING : ES_IDLE;
                end
            end
            default: begin
                next_esState = ES_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || chanReset) begin
            esState <= ES_IDLE;
        end else begin
            esState <= next_esState;
        end
    end

    // interrupt and latch-close outputs, both registered
    // rise closes latches
    always_ff @(posedge clk) begin
        if (rst) begin
            extStatusIrq <= 1'b0;
            extLatchClose <= 1'b0;
        end else begin
            extStatusIrq <= (next_esState != ES_IDLE);
            extLatchClose <= zcRise;
        end
    end

    // ------------------------------------------------------------
    // receive fifo and error latches
    // ------------------------------------------------------------
    logic rxFull;
    logic rxNotEmpty;
    logic rxPop;
    logic [RX_W-1:0] rxTop;
    logic [RX_W-1:0] rxEntry;
    logic [2:0] residueIn;
    logic overrunLatch;
    logic parityLatch;
    logic errMask;

    // boundary frames use the per-length code, others the receiver's code
    // boundary code by length
    always_comb begin
        case (cfg[CFG_CHAR_LEN_LSB +: 2])
            LEN_5: residueIn = RES_NONE_5;
            LEN_6: residueIn = RES_NONE_6;
            LEN_7: residueIn = RES_NONE_7;
            default: residueIn = RES_NONE_8;
        endcase
        if (!rxOnBoundary) begin
            residueIn = rxResidue;
        end
    end

    // the character that overwrites the newest entry carries the overrun mark
    // flag overwriting char
    // a pop in the same cycle makes room, so nothing is overwritten then
    assign rxEntry = {rxFull && !rxPop, residueIn, rxEndOfFrame && isSdlc, rxCrcErr && !isAsync,
                      rxFrameErr && isAsync, rxParityErr && cfg[CFG_PARITY_EN], rxData};
    assign rxPop = rdDone && paddr == OFS_RECEIVE_DATA;

    status_fifo #(
        .WIDTH(RX_W),
        .DEPTH(RX_DEPTH),
        .OVERWRITE(1'b1)
    ) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(chanReset),
        .push(rxPush),
        .pushData(rxEntry),
        .pop(rxPop),
        .topData(rxTop),
        .notEmpty(rxNotEmpty),
        .full(rxFull)
    );

    // latched errors; a new error beats error reset in the same cycle
    // parity latch
    always_ff @(posedge clk) begin
        if (rst || chanReset) begin
            parityLatch <= 1'b0;
        end else if (rxPush && rxEntry[RX_PAR]) begin
            parityLatch <= 1'b1;
        end else if (errReset) begin
            parityLatch <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || chanReset) begin
            overrunLatch <= 1'b0;
        end else if (rxPop && rxNotEmpty && rxTop[RX_OVR]) begin
            overrunLatch <= 1'b1;
        end else if (errReset) begin
            overrunLatch <= 1'b0;
        end
    end

    // error reset hides head crc/eof until the next character reaches the head
    // set by error reset, cleared by pop
    always_ff @(posedge clk) begin
        if (rst || chanReset) begin
            errMask <= 1'b0;
        end else if (rxPop || (rxPush && !rxNotEmpty)) begin
            errMask <= 1'b0;
        end else if (errReset) begin
            errMask <= 1'b1;
        end
    end

    // receiver stretches the stop bit by half a bit on framing error
    // half-bit stretch request
    always_ff @(posedge clk) begin
        if (rst) begin
            extendHalfBit <= 1'b0;
        end else begin
            extendHalfBit <= rxPush && rxFrameErr && isAsync;
        end
    end

    // ------------------------------------------------------------
    // frame status fifo
    // ------------------------------------------------------------
    logic frFull;
    logic frNotEmpty;
    logic frPop;
    logic [FR_W-1:0] frTop;
    logic frOverflow;

    assign frPop = rdDone && paddr == OFS_FRAME_COUNT_HIGH && frameFifoOn;

    status_fifo #(
        .WIDTH(FR_W),
        .DEPTH(FR_DEPTH),
        .OVERWRITE(1'b0)
    ) u_frame_fifo (
        .clk(clk),
        .rst(rst),
        .flush(chanReset || !frameFifoOn),
        .push(frameDone && frameFifoOn),
        .pushData({frameCrcErr, frameResidue, 1'b0, frameByteCount}), // spare bit keeps crc at the top
        .pop(frPop),
        .topData(frTop),
        .notEmpty(frNotEmpty),
        .full(frFull)
    );

    // overflow sticks until error reset; a new overflow wins
    // overflow flag
    always_ff @(posedge clk) begin
        if (rst || chanReset) begin
            frOverflow <= 1'b0;
        end else if (frameDone && frameFifoOn && frFull && !frPop) begin
            frOverflow <= 1'b1;
        end else if (errReset) begin
            frOverflow <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register views
    // ------------------------------------------------------------
    logic [7:0] specialView;
    logic [7:0] vectorB;
    logic [2:0] insStatus;
    logic [31:0] readMux;
    logic useFrame;

    assign useFrame = frameFifoOn && frNotEmpty;

    // special receive status
    always_comb begin
        specialView = 8'h00;
        specialView[7] = isSdlc && rxNotEmpty && rxTop[RX_EOF] && !errMask;
        if (useFrame) begin
            specialView[6] = frTop[FR_CRC];
        end else if (isAsync) begin
            specialView[6] = rxNotEmpty && rxTop[RX_FRM];
        end else begin
            specialView[6] = cfg[CFG_CRC_EN] && rxNotEmpty && rxTop[RX_CRC] && !errMask;
        end
        specialView[5] = overrunLatch || (rxNotEmpty && rxTop[RX_OVR]);
        specialView[4] = parityLatch;
        // residue leaves 011 only in sdlc
        if (useFrame) begin
            specialView[3:1] = frTop[FR_RES_LSB +: 3];
        end else if (isSdlc && rxNotEmpty) begin
            specialView[3:1] = rxTop[RX_RES_LSB +: 3];
        end else begin
            specialView[3:1] = RES_RESET;
        end
        specialView[0] = isAsync ? txAllSent : 1'b1;
    end

    // channel b vector with status inserted low or high
    always_comb begin
        insStatus = (ipPending != 6'h00) ? vectorStatus : VEC_NONE_LOW;
        vectorB = vectorReg;
        if (cfg[CFG_STATUS_HIGH]) begin
            vectorB[6:4] = (ipPending != 6'h00) ? {insStatus[0], insStatus[1], insStatus[2]} : VEC_NONE_HIGH;
        end else begin
            vectorB[3:1] = insStatus;
        end
    end

    // read multiplexer; unmapped addresses and the command register read zero, the vector write address reads back the vector
    always_comb begin
        readMux = 32'h0000_0000;
        case (paddr)
            OFS_BUF_EXT_STATUS: readMux[1:0] = {zcLive, rxNotEmpty};
            OFS_SPECIAL_RX: readMux[7:0] = specialView;
            OFS_VECTOR_CHAN_A: readMux[7:0] = vectorReg;
            OFS_PENDING_CHAN_A: readMux[7:0] = {2'h0, ipPending};
            OFS_PENDING_CHAN_B: readMux = 32'h0000_0000;
            OFS_FRAME_COUNT_LOW: readMux[7:0] = frameFifoOn ? frTop[7:0] : 8'h00;
            OFS_FRAME_COUNT_HIGH: readMux[7:0] = frameFifoOn ? {frOverflow, frNotEmpty, frTop[13:8]} : 8'h00;
            OFS_RECEIVE_DATA: readMux[7:0] = rxTop[7:0];
            OFS_VECTOR_CHAN_B: readMux[7:0] = vectorB;
            OFS_CONFIG: readMux[9:0] = cfg;
            OFS_VECTOR_WRITE: readMux[7:0] = vectorReg;
            default: readMux = 32'h0000_0000;
        endcase
    end

    // one wait state so read data leaves a flip-flop
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access && !pready;
            pslverr <= 1'b0;
            if (access && !pready && !pwrite) begin
                prdata <= readMux;
            end
        end
    end

    // special receive condition for vectoring
    // parity as special condition
    always_ff @(posedge clk) begin
        if (rst) begin
            specialRxCond <= 1'b0;
        end else begin
            specialRxCond <= overrunLatch || (rxNotEmpty && (rxTop[RX_OVR] || rxTop[RX_FRM]
                || (isSdlc && rxTop[RX_EOF] && !errMask)))
                || (cfg[CFG_PARITY_SPECIAL] && (parityLatch || (rxNotEmpty && rxTop[RX_PAR])));
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_zc_first;
        zcRise && esState == ES_IDLE && !chanReset;
    endsequence
    sequence s_irq_and_close;
        extStatusIrq && extLatchClose;
    endsequence
    sequence s_read_phase(logic [7:0] ofs);
        access && !pready && !pwrite && paddr == ofs;
    endsequence

    a_zc_level_follows: assert property (cfg[CFG_ZC_IE] && brgZero && !chanReset |=> zcLive)
        else $error("zero-count level lost");
    a_zc_immediate_irq: assert property (s_zc_first |=> s_irq_and_close)
        else $error("zero count did not raise interrupt");
    a_zc_queue_drop: assert property (esState == ES_ZC_QUEUED && esReset && !zcLive && !chanReset
        |=> esState == ES_IDLE ##1 !extStatusIrq)
        else $error("stale zero count kept");
    a_rx_flush_empty: assert property (chanReset |=> !rxNotEmpty)
        else $error("channel reset left receive data");
    a_eof_non_sdlc: assert property (!isSdlc |-> !specialView[7])
        else $error("end of frame outside sdlc");
    a_residue_async: assert property (isAsync |-> specialView[3:1] == 3'h3)
        else $error("residue not forced in async");
    a_all_sent_sync: assert property (!isAsync |-> specialView[0])
        else $error("all sent low in sync mode");
    a_overrun_latches: assert property (rxPop && rxNotEmpty && rxTop[RX_OVR] && !chanReset
        |=> overrunLatch [*2] or (overrunLatch ##1 errReset))
        else $error("overrun not latched");
    a_vector_chan_a: assert property (s_read_phase(OFS_VECTOR_CHAN_A) |=> pready && prdata == {24'h0, $past(vectorReg)})
        else $error("channel a vector modified");
    a_pending_chan_b: assert property (s_read_phase(OFS_PENDING_CHAN_B) |=> pready && prdata == 32'h0)
        else $error("channel b pending not zero");
    a_vector_none_low: assert property (ipPending == 6'h00 && !cfg[CFG_STATUS_HIGH] |-> vectorB[3:1] == 3'h3)
        else $error("idle vector status wrong");
    a_frame_not_empty: assert property (s_read_phase(OFS_FRAME_COUNT_HIGH) && frameFifoOn
        |=> prdata[6] == $past(frNotEmpty))
        else $error("frame fifo status bit wrong");
endmodule

// ---- tb/apb_host.sv ----
// apb master model standing in for the host processor
`timescale 1ns/10ps
module apb_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
    end
    // one transfer; request held until pready seen high at an edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 0;
        penable <= 0;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the channel read-status registers
`timescale 1ns/10ps
module tb_top;
    import serial_ctrl_pkg::*;
    logic clk = 0, rst = 1, brgZero = 0, rxPush = 0, txAllSent = 0, frameDone = 0, frameCrcErr = 0;
    logic rxParityErr = 0, rxFrameErr = 0, rxCrcErr = 0, rxEndOfFrame = 0, rxOnBoundary = 0;
    logic [7:0] rxData = 0, v;
    logic [2:0] rxResidue = 0, frameResidue = 0, vectorStatus = 0;
    logic [13:0] frameByteCount = 0;
    logic [5:0] ipPending = 0;
    logic psel, penable, pwrite, pready, pslverr, extStatusIrq, extLatchClose, extendHalfBit, specialRxCond;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] q[$];
    int n_fail = 0, check_count = 0, i;
    always #50 clk = ~clk;
    serial_ctrl_read_status_regs dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .brgZero, .rxPush, .rxData, .rxParityErr, .rxFrameErr, .rxCrcErr, .rxEndOfFrame,
        .rxOnBoundary, .rxResidue, .txAllSent, .frameDone, .frameByteCount, .frameCrcErr, .frameResidue,
        .ipPending, .vectorStatus, .extStatusIrq, .extLatchClose, .extendHalfBit, .specialRxCond);
    apb_host host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
    task chk(string s, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task rd(logic [7:0] a);
        host.xfer(0, a, 0, r);
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        host.xfer(1, a, d, r);
    endtask
    // receiver push; a full fifo overwrites its newest entry
    task push(logic [7:0] d);
        @(posedge clk);
        rxPush <= 1;
        rxData <= d;
        @(posedge clk);
        rxPush <= 0;
        if (q.size() == RX_DEPTH) q[RX_DEPTH-1] = d;
        else q.push_back(d);
    endtask
    // watchdog, far beyond the expected run length
    initial begin
        #3000000;
        n_fail++;
        finish_test;
    end
    initial begin
        i = $urandom(87899);
        repeat (12) @(posedge clk);
        rst <= 0;
        rd(OFS_CONFIG); chk("config", r, 0);
        rd(8'h3c); chk("unmapped", r, 0);
        txAllSent <= 1;
        rd(OFS_SPECIAL_RX); chk("async status", r, 32'h7);
        wr(OFS_CONFIG, MODE_SYNC);
        txAllSent <= 0;
        rd(OFS_SPECIAL_RX); chk("sync all sent", r, 32'h7);
        wr(OFS_CONFIG, 0);
        rd(OFS_BUF_EXT_STATUS); chk("rx empty", r[0], 0);
        for (i = 0; i < 4; i++) push(8'($urandom));
        rd(OFS_BUF_EXT_STATUS); chk("rx avail", r[0], 1);
        for (i = 0; i < RX_DEPTH; i++) begin
            rd(OFS_RECEIVE_DATA); chk("rx data", r[7:0], q.pop_front());
        end
        rd(OFS_SPECIAL_RX); chk("overrun latch", r, 32'h26);
        wr(OFS_COMMAND, 1);
        rd(OFS_SPECIAL_RX); chk("error reset", r, 32'h6);
        wr(OFS_CONFIG, (1 << CFG_PARITY_EN) | (1 << CFG_PARITY_SPECIAL));
        rxFrameErr <= 1;
        rxParityErr <= 1;
        push(8'h5a);
        @(negedge clk);
        chk("half bit", extendHalfBit, 1);
        rxFrameErr <= 0;
        rxParityErr <= 0;
        rd(OFS_SPECIAL_RX); chk("framing parity", r, 32'h56);
        rd(OFS_RECEIVE_DATA); chk("rx data", r[7:0], q.pop_front());
        rd(OFS_SPECIAL_RX); chk("parity latch", r, 32'h16);
        chk("parity special", specialRxCond, 1);
        wr(OFS_COMMAND, 1);
        repeat (2) @(negedge clk);
        chk("special clear", specialRxCond, 0);
        wr(OFS_CONFIG, 1 << CFG_ZC_IE);
        brgZero <= 1;
        repeat (2) @(negedge clk);
        chk("latch close", extLatchClose, 1);
        rd(OFS_BUF_EXT_STATUS); chk("zero count", r[1], 1);
        chk("es irq", extStatusIrq, 1);
        brgZero <= 0;
        rd(OFS_BUF_EXT_STATUS); chk("zero unlatched", r[1], 0);
        brgZero <= 1;
        rd(OFS_BUF_EXT_STATUS);
        brgZero <= 0;
        rd(OFS_BUF_EXT_STATUS);
        wr(OFS_COMMAND, 2);
        @(negedge clk);
        chk("stale zc dropped", extStatusIrq, 0);
        push(8'h11);
        wr(OFS_COMMAND, 4);
        q.delete();
        rd(OFS_CONFIG); chk("chan reset cfg", r, 0);
        rd(OFS_BUF_EXT_STATUS); chk("chan reset rx", r[0], 0);
        v = 8'($urandom);
        wr(OFS_VECTOR_WRITE, v);
        rd(OFS_VECTOR_CHAN_A); chk("vector a", r, v);
        rd(OFS_VECTOR_CHAN_B); chk("vector b low", r, (v & 8'hf1) | 8'h06);
        wr(OFS_CONFIG, 1 << CFG_STATUS_HIGH);
        rd(OFS_VECTOR_CHAN_B); chk("vector b high", r, (v & 8'h8f) | 8'h60);
        ipPending <= 6'($urandom) | 6'h01;
        vectorStatus <= 3'($urandom);
        rd(OFS_PENDING_CHAN_A); chk("pending a", r, ipPending);
        rd(OFS_PENDING_CHAN_B); chk("pending b", r, 0);
        chk("no slave error", pslverr, 0);
        rd(OFS_VECTOR_CHAN_B);
        chk("vector b status", r, {v[7], vectorStatus[0], vectorStatus[1], vectorStatus[2], v[3:0]});
        wr(OFS_CONFIG, MODE_SDLC | (1 << CFG_CRC_EN));
        rxEndOfFrame <= 1;
        rxCrcErr <= 1;
        rxOnBoundary <= 1;
        push(8'h3c);
        rxEndOfFrame <= 0;
        rxCrcErr <= 0;
        rxOnBoundary <= 0;
        rd(OFS_SPECIAL_RX); chk("sdlc boundary", r, 32'hc9);
        wr(OFS_COMMAND, 1);
        rd(OFS_SPECIAL_RX); chk("error reset mask", r, 32'h09);
        rd(OFS_RECEIVE_DATA); chk("rx data", r[7:0], q.pop_front());
        rxResidue <= 3'($urandom);
        push(8'hc3);
        rd(OFS_SPECIAL_RX); chk("residue code", r[3:1], rxResidue);
        rd(OFS_RECEIVE_DATA); chk("rx data", r[7:0], q.pop_front());
        wr(OFS_CONFIG, MODE_SDLC | (1 << CFG_FRAME_FIFO_EN));
        frameByteCount <= 14'($urandom);
        frameResidue <= 3'($urandom);
        frameCrcErr <= 1;
        @(posedge clk) frameDone <= 1;
        @(posedge clk) frameDone <= 0;
        rd(OFS_SPECIAL_RX); chk("frame crc", r, 32'h41 | (frameResidue << 1));
        rd(OFS_FRAME_COUNT_LOW); chk("count low", r, frameByteCount[7:0]);
        rd(OFS_FRAME_COUNT_HIGH); chk("count high", r, 8'h40 | frameByteCount[13:8]);
        rd(OFS_FRAME_COUNT_HIGH); chk("frame empty", r[7:6], 0);
        finish_test;
    end
endmodule
